// *** pkg/bie_pkg.sv ***
// Shared constants, types and decode helpers for the jump and increment executor.
// Assumes a 14-bit instruction word, a 13-bit program counter and 8-bit data.
package bie_pkg;

	localparam int BIE_IW     = 14;
	localparam int BIE_PCW    = 13;
	localparam int BIE_DW     = 8;
	localparam int BIE_FW     = 7;
	localparam int BIE_LITW   = 11;
	localparam int BIE_LATCHW = 8;

	// Jump: top three bits 10 1, then an 11-bit literal
	localparam int              BIE_JUMP_MSB = 13;
	localparam int              BIE_JUMP_LSB = 11;
	localparam logic [2:0]      BIE_JUMP_OP  = 3'h5;
	// Increment: 00 1010 d fffffff
	localparam int              BIE_OPC_MSB  = 13;
	localparam int              BIE_OPC_LSB  = 8;
	localparam logic [5:0]      BIE_INC_OP   = 6'h0a;
	localparam int              BIE_DEST_BIT = 7;
	// Latch bits that feed the top of the program counter
	localparam int              BIE_LATCH_HI = 4;
	localparam int              BIE_LATCH_LO = 3;

	// Four phases per instruction cycle at the 100 ns clock
	localparam int              BIE_PHASES      = 4;
	localparam logic [3:0]      BIE_PHASE_RST   = 4'h8;
	localparam logic [13:0]     BIE_IR_RST      = 14'h0000;
	localparam logic [12:0]     BIE_PC_RST      = 13'h0000;
	localparam logic [12:0]     BIE_PC_STEP     = 13'h0001;
	localparam logic [7:0]      BIE_DATA_RST    = 8'h00;
	localparam logic [7:0]      BIE_DATA_ONE    = 8'h01;
	localparam logic [6:0]      BIE_ADDR_RST    = 7'h00;

	typedef enum logic [0:0] {BIE_ST_EXEC, BIE_ST_FLUSH} bie_state_t;

	// q1 in the top bit, rotating toward q4
	typedef struct packed {
		logic q1;
		logic q2;
		logic q3;
		logic q4;
	} bie_phase_t;

	typedef struct packed {
		logic                  we;
		logic [BIE_FW-1:0]     addr;
		logic [BIE_DW-1:0]     data;
	} bie_regwr_t;

	function automatic logic bie_is_jump(input logic [BIE_IW-1:0] w);
		return w[BIE_JUMP_MSB:BIE_JUMP_LSB] == BIE_JUMP_OP;
	endfunction

	function automatic logic bie_is_incr(input logic [BIE_IW-1:0] w);
		return w[BIE_OPC_MSB:BIE_OPC_LSB] == BIE_INC_OP;
	endfunction

	function automatic logic [BIE_DW-1:0] bie_inc(input logic [BIE_DW-1:0] d);
		return d + BIE_DATA_ONE;
	endfunction

endpackage

// *** hdl/bie_phase_gen.sv ***
// Four-phase generator: one-hot q1..q4 enables, each one clock long.
// Assumes a single free-running clock; the phases rotate from reset on.
`timescale 1ns/1ps
`default_nettype none
module bie_phase_gen
	import bie_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	output bie_phase_t       phase
);

	// One-hot rotation keeps every phase enable a plain flop output
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			phase <= BIE_PHASE_RST;
		else
			phase <= {phase[0], phase[3:1]};
	end

endmodule // bie_phase_gen
`default_nettype wire

// *** hdl/bie_exec.sv ***
// Jump and increment executor of the core, stepped by four clock phases.
// Assumes the fetch path presents the next word before q1 and the register
// file answers a read address within one clock.
`timescale 1ns/1ps
`default_nettype none
module bie_exec
	import bie_pkg::*;
(
	input  wire logic [BIE_IW-1:0]     instr_word,
	input  wire logic [BIE_LATCHW-1:0] program_counter_high_latch,
	input  wire logic [BIE_DW-1:0]     reg_rdata,
	input  wire logic                  clock,
	input  wire logic                  rst,
	output logic [BIE_PCW-1:0]         pc,
	output logic                       pc_load,
	output logic                       flush,
	output logic [BIE_FW-1:0]          reg_raddr,
	output bie_regwr_t                 reg_wr,
	output logic                       acc_we,
	output logic [BIE_DW-1:0]          acc_data,
	output logic                       zero_flag,
	output logic                       zero_we
);

	bie_phase_t              phase;
	bie_state_t              state;
	logic [BIE_IW-1:0]       ir;
	logic [BIE_DW-1:0]       operand;
	logic [BIE_DW-1:0]       result;
	logic                    jump_now;
	logic                    incr_now;
	logic [BIE_LITW-1:0]     jump_lit;
	logic [1:0]              latch_hi;
	logic [2:0]              jump_fld;

	bie_phase_gen u_phase
	(
		.clock (clock),
		.rst   (rst),
		.phase (phase)
	);

	assign jump_fld = ir[BIE_JUMP_MSB:BIE_JUMP_LSB];
	assign jump_lit = ir[BIE_LITW-1:0];
	assign latch_hi = program_counter_high_latch[BIE_LATCH_HI:BIE_LATCH_LO];
	assign jump_now = (state == BIE_ST_EXEC) && bie_is_jump(ir);
	assign incr_now = (state == BIE_ST_EXEC) && bie_is_incr(ir);

	// Instruction capture; during the flush cycle the fetched word is dropped
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ir        <= BIE_IR_RST;
			reg_raddr <= BIE_ADDR_RST;
		end
		else if (phase.q1)
		begin
			if (state == BIE_ST_FLUSH)
				ir <= BIE_IR_RST;
			else
				ir <= instr_word;
			reg_raddr <= instr_word[BIE_FW-1:0];
		end
	end

	// Cycle sequencing: a jump forces one extra all-idle cycle
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state <= BIE_ST_EXEC;
			flush <= 1'b0;
		end
		else if (phase.q4)
		begin
			case (state)
				BIE_ST_EXEC:
				begin
					if (jump_now)
					begin
						state <= BIE_ST_FLUSH;
						flush <= 1'b1;
					end
				end
				BIE_ST_FLUSH:
				begin
					state <= BIE_ST_EXEC;
					flush <= 1'b0;
				end
				default:
				begin
					state <= BIE_ST_EXEC;
					flush <= 1'b0;
				end
			endcase
		end
	end

	// Operand read in q2, processed in q3
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			operand <= BIE_DATA_RST;
			result  <= BIE_DATA_RST;
		end
		else
		begin
			if (phase.q2)
				operand <= reg_rdata;
			if (phase.q3)
				result <= bie_inc(operand);
		end
	end

	// Program counter: written only in q4; held through the flush cycle
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pc      <= BIE_PC_RST;
			pc_load <= 1'b0;
		end
		else
		begin
			pc_load <= 1'b0;
			if (phase.q4 && jump_now)
			begin
				pc      <= {latch_hi, jump_lit};
				pc_load <= 1'b1;
			end
			else if (phase.q4 && state == BIE_ST_EXEC)
				pc <= pc + BIE_PC_STEP;
		end
	end

	// Destination write in q4; strobes last one clock
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			reg_wr   <= '0;
			acc_we   <= 1'b0;
			acc_data <= BIE_DATA_RST;
		end
		else
		begin
			reg_wr.we <= 1'b0;
			acc_we    <= 1'b0;
			if (phase.q4 && incr_now)
			begin
				if (ir[BIE_DEST_BIT])
				begin
					reg_wr.we   <= 1'b1;
					reg_wr.addr <= ir[BIE_FW-1:0];
					reg_wr.data <= result;
				end
				else
				begin
					acc_we   <= 1'b1;
					acc_data <= result;
				end
			end
		end
	end

	// Zero flag touched only by the increment; a jump leaves it alone
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			zero_flag <= 1'b0;
			zero_we   <= 1'b0;
		end
		else
		begin
			zero_we <= 1'b0;
			if (phase.q4 && incr_now)
			begin
				zero_flag <= (result == BIE_DATA_RST);
				zero_we   <= 1'b1;
			end
		end
	end

	// Checks
	jump_decode_a: assert property (@(posedge clock) disable iff (rst)
		pc_load |-> $past(jump_fld) == BIE_JUMP_OP)
		else $error("pc loaded without jump opcode");

	lit_load_a: assert property (@(posedge clock) disable iff (rst)
		(phase.q4 && jump_now) |=> pc[BIE_LITW-1:0] == $past(jump_lit))
		else $error("jump literal not in low pc bits");

	high_fill_a: assert property (@(posedge clock) disable iff (rst)
		(phase.q4 && jump_now) |=> pc[BIE_PCW-1:BIE_LITW] == $past(latch_hi))
		else $error("pc high bits not from latch");

	flush_cycle_a: assert property (@(posedge clock) disable iff (rst)
		(phase.q4 && jump_now) |=> flush [*4] ##1 !flush)
		else $error("jump second cycle not four phases");

	flush_idle_a: assert property (@(posedge clock) disable iff (rst)
		flush |-> ##1 (!acc_we && !reg_wr.we && !zero_we && $stable(pc)))
		else $error("activity during jump idle cycle");

	inc_acc_a: assert property (@(posedge clock) disable iff (rst)
		acc_we |-> (acc_data == bie_inc(operand)) && !ir[BIE_DEST_BIT]
			&& bie_is_incr(ir))
		else $error("bad increment to accumulator");

	inc_reg_a: assert property (@(posedge clock) disable iff (rst)
		reg_wr.we |-> (reg_wr.data == bie_inc(operand)) && ir[BIE_DEST_BIT]
			&& (reg_wr.addr == reg_raddr))
		else $error("bad increment to register");

	inc_zero_a: assert property (@(posedge clock) disable iff (rst)
		(phase.q1 && !flush && bie_is_incr(instr_word)) |-> ##4
			(zero_we && zero_flag == (bie_inc(operand) == BIE_DATA_RST)))
		else $error("increment zero flag wrong or late");

	jump_keep_z_a: assert property (@(posedge clock) disable iff (rst)
		pc_load |-> !zero_we && $stable(zero_flag))
		else $error("jump changed status flag");

	jump_seen_c: cover property (@(posedge clock) disable iff (rst)
		pc_load ##1 flush [*3]);

	inc_acc_c: cover property (@(posedge clock) disable iff (rst)
		acc_we && zero_flag);

	inc_reg_c: cover property (@(posedge clock) disable iff (rst)
		reg_wr.we && !zero_flag);

endmodule // bie_exec
`default_nettype wire

// *** sim/branch_and_increment_exec_bench.sv ***
// Self-checking bench for the jump and increment executor.
// Assumes the phase counter restarts at q1 on the first edge after reset.
`timescale 1ns/1ps
`default_nettype none
module branch_and_increment_exec_bench
	import bie_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [13:0] iw = 14'h0000;
	logic [7:0]  latch = 8'h00;
	logic [7:0]  rdata = 8'h00;
	logic [12:0] pc;
	logic        pc_load;
	logic        flush;
	logic [6:0]  raddr;
	bie_regwr_t  reg_wr;
	logic        acc_we;
	logic [7:0]  acc_data;
	logic        zero_flag;
	logic        zero_we;
	int          failures = 0;
	int          samples_checked = 0;
	logic [12:0] exp_pc = 13'h0000;

	bie_exec DUT (
		.instr_word                 (iw),
		.program_counter_high_latch (latch),
		.reg_rdata                  (rdata),
		.clock                      (clock),
		.rst                        (rst),
		.pc                         (pc),
		.pc_load                    (pc_load),
		.flush                      (flush),
		.reg_raddr                  (raddr),
		.reg_wr                     (reg_wr),
		.acc_we                     (acc_we),
		.acc_data                   (acc_data),
		.zero_flag                  (zero_flag),
		.zero_we                    (zero_we)
	);

	always #50 clock = ~clock;

	task automatic chk_bit(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s exp %b got %b", n, e, g);
		end
	endtask

	task automatic chk_vec(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One word per instruction cycle; returns on the falling edge after q4
	task automatic step(input logic [13:0] w, input logic [7:0] d);
		iw = w;
		rdata = d;
		repeat (4) @(posedge clock);
		@(negedge clock);
	endtask

	// Strobes stand one clock, so they are looked at right after q4
	task automatic strobes(input logic pl, fl, aw, rw, zw);
		chk_bit("pc_load", pl, pc_load);
		chk_bit("flush", fl, flush);
		chk_bit("acc_we", aw, acc_we);
		chk_bit("reg_we", rw, reg_wr.we);
		chk_bit("zero_we", zw, zero_we);
		chk_vec("pc", {3'h0, exp_pc}, {3'h0, pc});
	endtask

	task automatic t_inc_reg;
		step(14'h0aff, 8'h41);
		exp_pc = exp_pc + 13'h0001;
		strobes(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		chk_vec("reg_wr", {1'b1, 7'h7f, 8'h42}, reg_wr);
		chk_bit("zero", 1'b0, zero_flag);
		$display("done inc_reg");
	endtask

	// Wrap from ff gives zero, the awkward edge of the flag
	task automatic t_inc_acc;
		step(14'h0a15, 8'hff);
		exp_pc = exp_pc + 13'h0001;
		strobes(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		chk_vec("acc_data", 16'h0000, {8'h00, acc_data});
		chk_vec("raddr", 16'h0015, {9'h000, raddr});
		chk_bit("zero", 1'b1, zero_flag);
		$display("done inc_acc");
	endtask

	// Latch bits other than 4..3 are set to catch a wrong slice
	task automatic t_jump(input logic [7:0] l, input logic [10:0] k, input logic [13:0] w2);
		latch = l;
		step({3'h5, k}, 8'h00);
		exp_pc = {l[4:3], k};
		strobes(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk_bit("zero", 1'b1, zero_flag);
		step(w2, 8'hff);
		strobes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("done jump");
	endtask

	// Near misses of both opcodes only advance the counter
	task automatic t_other(input logic [13:0] w);
		step(w, 8'hff);
		exp_pc = exp_pc + 13'h0001;
		strobes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("done other");
	endtask

	initial
	begin
		#20000;
		failures++;
		end_sim();
	end

	initial
	begin
		repeat (10) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		t_inc_reg();
		t_inc_acc();
		t_jump(8'he8, 11'h155, 14'h0a15);
		t_jump(8'h17, 11'h7ff, 14'h2800);
		// Zero flag is still set here, so this also proves it clears
		t_inc_reg();
		t_other(14'h3000);
		t_other(14'h0b00);
		t_other(14'h2000);
		end_sim();
	end
endmodule // branch_and_increment_exec_bench
`default_nettype wire
